// [include/slasu_pkg.sv]
// Purpose: shared constants and types for the shift execution unit
// Assumes: 24-bit instruction words, 16-bit data, 40-bit accumulators
// Notes:   opcodes are matched on the top byte of the instruction word
package slasu_pkg;
  localparam int DW        = 16;
  localparam int AW        = 40;
  localparam int NUM_DEFAULT_WORK_REG  = 16;
  localparam int SH_GUARD  = 16;   // headroom bits above the accumulator while shifting
  localparam int SAT_MSB   = 31;   // saturated values fit a signed 32-bit range
  localparam int FADDR_W   = 13;
  localparam int SAT_FIRST_BIT  = 7;
  localparam int SAT_SECOND_BIT = 6;

  localparam logic [7:0] OPC_ACC_SHIFT = 8'hc8;
  localparam logic [7:0] OPC_SHL_FILE  = 8'hd4;
  localparam logic [7:0] OPC_SHL_REG   = 8'hd0;
  localparam logic [7:0] OPC_SHL_LIT   = 8'hdd;
  localparam logic [2:0] LIT_PATTERN   = 3'h4;
  localparam logic [10:0] ACC_ZERO_FIELD = 11'h000;

  localparam logic signed [5:0] AMT_MAX = 6'sh10;  // +16
  localparam logic signed [5:0] AMT_MIN = 6'sh30;  // -16

  // operand addressing modes of the register form
  localparam logic [2:0] AM_DIRECT  = 3'h0;
  localparam logic [2:0] AM_POSTDEC = 3'h2;
  localparam logic [2:0] AM_POSTINC = 3'h3;
  localparam logic [2:0] AM_PREDEC  = 3'h4;
  localparam logic [2:0] AM_PREINC  = 3'h5;

  localparam logic [15:0] STEP_BYTE = 16'h0001;
  localparam logic [15:0] STEP_WORD = 16'h0002;
  localparam logic [3:0]  DEFAULT_WORK_REG = 4'h0;
  localparam logic [39:0] SAT_POS = 40'h007fffffff;
  localparam logic [39:0] SAT_NEG = 40'hff80000000;
  localparam logic [39:0] ACC_RESET = 40'h0000000000;
  localparam logic [15:0] DEFAULT_WORK_REG_RESET = 16'h0000;

  typedef enum logic [2:0] {
    OP_NONE      = 3'b000,
    OP_ACC_ARITH = 3'b001,
    OP_SHL_F     = 3'b010,
    OP_SHL_W     = 3'b011,
    OP_SHL_K     = 3'b100
  } slasu_op_t;

  typedef struct packed {
    logic        valid;
    logic        byte_op;
    logic [15:0] addr;
    logic [15:0] data;
  } slasu_wr_t;

  typedef struct packed {
    logic negative;
    logic zero;
    logic carry;
    logic overflow_flag_first;
    logic overflow_flag_second;
    logic overflow_flag_either;
    logic clamp_flag_first;
    logic clamp_flag_second;
    logic clamp_flag_either;
  } slasu_stat_t;
endpackage : slasu_pkg

// [hdl/slasu_acc_shifter.sv]
// Purpose: 40-bit arithmetic accumulator shifter with optional clamping
// Assumes: amount is signed, negative shifts left, positive shifts right
// Notes:   purely combinational; the caller registers the result
`timescale 1ns/100ps
`default_nettype none
module slasu_acc_shifter (
  input  wire logic [39:0]       acc_in,
  input  wire logic signed [5:0] amt,
  input  wire logic              sat_en,
  output logic [39:0]            acc_out,
  output logic                   range_err,
  output logic                   ovf,
  output logic                   sat_hit
);
  import slasu_pkg::*;
  localparam int WW = AW + SH_GUARD;

  logic [WW-1:0] ext;
  logic [WW-1:0] wide;
  logic [5:0]    mag;
  logic          lost_top;
  logic          guard_ovf;

  // guard bits keep left-shifted sign information so loss can be detected
  always_comb begin
    range_err = (amt > AMT_MAX) || (amt < AMT_MIN);
    mag       = amt[5] ? 6'(-amt) : 6'(amt);
    ext       = {{SH_GUARD{acc_in[AW-1]}}, acc_in};
    if (amt[5]) begin
      wide = ext << mag;                       // bits off the top are dropped
    end else begin
      wide = WW'($signed(ext) >>> mag);        // sign copied in from the top
    end
    lost_top  = |wide[WW-1:AW-1] && !(&wide[WW-1:AW-1]);
    guard_ovf = |wide[AW-1:SAT_MSB] && !(&wide[AW-1:SAT_MSB]);
    acc_out   = wide[AW-1:0];
    ovf       = guard_ovf;
    sat_hit   = lost_top;
    // clamping trades the guard bits for a result that never wraps
    if (sat_en && (lost_top || guard_ovf)) begin
      acc_out = wide[WW-1] ? SAT_NEG : SAT_POS;
      ovf     = 1'h0;
      sat_hit = 1'h1;
    end
  end
endmodule : slasu_acc_shifter
`default_nettype wire

// [hdl/slasu_unit.sv]
// Purpose: executes the accumulator arithmetic shift and the left shift group
// Assumes: the core presents file or indirect source data on operand_rdata
// Notes:   results, flags and memory writes appear one edge after acceptance
`timescale 1ns/100ps
`default_nettype none
module slasu_unit (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic             instr_valid,
  input  wire logic [23:0]      instr,
  input  wire logic [15:0]      operand_rdata,
  input  wire logic [15:0]      core_control_reg,
  input  wire logic             clamp_flag_clear,
  input  wire logic             ext_wr_en,
  input  wire logic [3:0]       ext_wr_sel,
  input  wire logic [15:0]      ext_wr_data,
  input  wire logic             acc_ld_en,
  input  wire logic             acc_ld_sel,
  input  wire logic [39:0]      acc_ld_data,
  input  wire logic [3:0]       rd_sel,
  output logic [15:0]           rd_data,
  output slasu_pkg::slasu_wr_t   mem_wr,
  output slasu_pkg::slasu_stat_t status,
  output logic                  arith_trap,
  output logic [39:0]           accumulator_first,
  output logic [39:0]           accumulator_second
);
  import slasu_pkg::*;

  slasu_op_t   op;
  logic [15:0] default_work_reg_r [NUM_DEFAULT_WORK_REG];
  logic [15:0] wnx    [NUM_DEFAULT_WORK_REG];
  logic [39:0] acc_r  [2];
  logic [15:0] rd_data_r;
  slasu_wr_t   wr_r;
  slasu_wr_t   wr_nxt;
  slasu_stat_t stat_r;
  slasu_stat_t stat_nxt;
  logic        trap_r;

  logic               acc_sel;
  logic [3:0]         cnt_reg;
  logic               byte_op;
  logic               file_dest;
  logic [FADDR_W-1:0] faddr;
  logic [2:0]         dst_mode;
  logic [3:0]         dst_reg;
  logic [2:0]         src_mode;
  logic [3:0]         src_reg;
  logic [3:0]         lit_base;
  logic [3:0]         lit_cnt;
  logic [15:0]        step;

  logic [15:0] src_val;
  logic [15:0] one_res;
  logic        one_c;
  logic        one_n;
  logic        one_z;
  logic [15:0] lit_res;

  logic signed [5:0] sh_amt;
  logic        sh_sat_en;
  logic [39:0] sh_out;
  logic        sh_err;
  logic        sh_ovf;
  logic        sh_sat;
  logic        acc_ok;

  // effective address: pre-modify modes use the updated pointer
  function automatic logic [15:0] eff_addr(input logic [2:0]  m,
                                           input logic [15:0] w,
                                           input logic [15:0] st);
    case (m)
      AM_PREDEC: eff_addr = w - st;
      AM_PREINC: eff_addr = w + st;
      default:   eff_addr = w;
    endcase
  endfunction : eff_addr

  // pointer write-back for the four modifying modes
  function automatic logic [15:0] ptr_next(input logic [2:0]  m,
                                           input logic [15:0] w,
                                           input logic [15:0] st);
    case (m)
      AM_POSTDEC, AM_PREDEC: ptr_next = w - st;
      AM_POSTINC, AM_PREINC: ptr_next = w + st;
      default:               ptr_next = w;
    endcase
  endfunction : ptr_next

  // instruction fields, shared by the forms that use them
  assign acc_sel   = instr[15];
  assign cnt_reg   = instr[3:0];
  assign byte_op   = instr[14];
  assign file_dest = instr[13];
  assign faddr     = instr[FADDR_W-1:0];
  assign dst_mode  = instr[13:11];
  assign dst_reg   = instr[10:7];
  assign src_mode  = instr[6:4];
  assign src_reg   = instr[3:0];
  assign lit_base  = instr[14:11];
  assign lit_cnt   = instr[3:0];
  assign step      = byte_op ? STEP_BYTE : STEP_WORD;

  // decode; one word per instruction and nothing is stretched here, so a
  // core with slow peripheral reads must hold instr_valid low until the
  // operand is ready
  always_comb begin
    op = OP_NONE;
    if (instr_valid) begin
      case (instr[23:16])
        OPC_ACC_SHIFT: if (instr[14:4] == ACC_ZERO_FIELD) op = OP_ACC_ARITH;
        OPC_SHL_FILE:  if (!instr[15]) op = OP_SHL_F;
        OPC_SHL_REG:   if (!instr[15]) op = OP_SHL_W;
        OPC_SHL_LIT:   if (!instr[15] && src_mode == LIT_PATTERN) op = OP_SHL_K;
        default:       op = OP_NONE;
      endcase
    end
  end

  // source operand: file and indirect data come from the core's fetch
  always_comb begin
    case (op)
      OP_SHL_W: src_val = (src_mode == AM_DIRECT) ? default_work_reg_r[src_reg] : operand_rdata;
      OP_SHL_K: src_val = default_work_reg_r[lit_base];     // direct only
      default:  src_val = operand_rdata;
    endcase
  end

  // one-bit shift: top bit to carry, zero into bit 0
  always_comb begin
    if (byte_op) begin
      one_res = {8'h00, src_val[6:0], 1'h0};
      one_c   = src_val[7];
      one_n   = one_res[7];
      one_z   = one_res[7:0] == 8'h00;
    end else begin
      one_res = {src_val[14:0], 1'h0};
      one_c   = src_val[15];
      one_n   = one_res[15];
      one_z   = one_res == 16'h0000;
    end
  end

  // literal shift is always a word; overflowing bits fall off
  assign lit_res = src_val << lit_cnt;

  // accumulator path
  assign sh_amt    = default_work_reg_r[cnt_reg][5:0];
  assign sh_sat_en = acc_sel ? core_control_reg[SAT_SECOND_BIT]
                             : core_control_reg[SAT_FIRST_BIT];
  assign acc_ok    = (op == OP_ACC_ARITH) && !sh_err;

  slasu_acc_shifter u_shifter (
    .acc_in    (acc_r[acc_sel]),
    .amt       (sh_amt),
    .sat_en    (sh_sat_en),
    .acc_out   (sh_out),
    .range_err (sh_err),
    .ovf       (sh_ovf),
    .sat_hit   (sh_sat)
  );

  // accumulators; an instruction write beats a same-cycle load
  for (genvar j = 0; j < 2; j++) begin : g_acc
    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        acc_r[j] <= ACC_RESET;
      end else if (acc_ok && acc_sel == 1'(j)) begin
        acc_r[j] <= sh_out;
      end else if (acc_ld_en && acc_ld_sel == 1'(j)) begin
        acc_r[j] <= acc_ld_data;
      end
    end
  end

  // work registers: load port first, then pointer and result updates
  for (genvar i = 0; i < NUM_DEFAULT_WORK_REG; i++) begin : g_default_work_reg
    always_comb begin
      wnx[i] = default_work_reg_r[i];
      if (ext_wr_en && ext_wr_sel == 4'(i)) begin
        wnx[i] = ext_wr_data;
      end
      case (op)
        OP_SHL_F: if (!file_dest && DEFAULT_WORK_REG == 4'(i)) begin
          wnx[i] = byte_op ? {default_work_reg_r[i][15:8], one_res[7:0]} : one_res;
        end
        OP_SHL_W: begin
          if (src_reg == 4'(i)) begin
            wnx[i] = ptr_next(src_mode, wnx[i], step);
          end
          if (dst_reg == 4'(i)) begin
            if (dst_mode == AM_DIRECT) begin
              wnx[i] = byte_op ? {wnx[i][15:8], one_res[7:0]} : one_res;
            end else begin
              wnx[i] = ptr_next(dst_mode, wnx[i], step);
            end
          end
        end
        OP_SHL_K: if (dst_reg == 4'(i)) wnx[i] = lit_res;
        default: wnx[i] = wnx[i];
      endcase
    end
    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        default_work_reg_r[i] <= DEFAULT_WORK_REG_RESET;
      end else begin
        default_work_reg_r[i] <= wnx[i];
      end
    end
  end

  // memory write request for file and indirect destinations
  always_comb begin
    wr_nxt = '0;
    if (op == OP_SHL_F && file_dest) begin
      wr_nxt.valid   = 1'h1;
      wr_nxt.byte_op = byte_op;
      wr_nxt.addr    = {3'h0, faddr};
      wr_nxt.data    = byte_op ? {one_res[7:0], one_res[7:0]} : one_res;
    end else if (op == OP_SHL_W && dst_mode != AM_DIRECT) begin
      wr_nxt.valid   = 1'h1;
      wr_nxt.byte_op = byte_op;
      wr_nxt.addr    = eff_addr(dst_mode, default_work_reg_r[dst_reg], step);
      wr_nxt.data    = byte_op ? {one_res[7:0], one_res[7:0]} : one_res;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wr_r <= '0;
    end else begin
      wr_r <= wr_nxt;
    end
  end

  // status: a clamp event in the clearing cycle still sets its flag
  always_comb begin
    stat_nxt = stat_r;
    if (op == OP_SHL_F || op == OP_SHL_W) begin
      stat_nxt.negative = one_n;
      stat_nxt.zero     = one_z;
      stat_nxt.carry    = one_c;
    end
    if (op == OP_SHL_K) begin
      stat_nxt.negative = lit_res[15];
      stat_nxt.zero     = lit_res == 16'h0000;
    end
    if (clamp_flag_clear) begin
      stat_nxt.clamp_flag_first  = 1'h0;
      stat_nxt.clamp_flag_second = 1'h0;
    end
    if (acc_ok) begin
      if (!acc_sel) begin
        stat_nxt.overflow_flag_first = sh_ovf;
        if (sh_sat) stat_nxt.clamp_flag_first = 1'h1;
      end else begin
        stat_nxt.overflow_flag_second = sh_ovf;
        if (sh_sat) stat_nxt.clamp_flag_second = 1'h1;
      end
    end
    stat_nxt.overflow_flag_either = stat_nxt.overflow_flag_first
                                  | stat_nxt.overflow_flag_second;
    stat_nxt.clamp_flag_either    = stat_nxt.clamp_flag_first
                                  | stat_nxt.clamp_flag_second;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stat_r <= '0;
    end else begin
      stat_r <= stat_nxt;
    end
  end

  // trap is a one-cycle pulse per out-of-range accumulator shift
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      trap_r <= 1'h0;
    end else begin
      trap_r <= (op == OP_ACC_ARITH) && sh_err;
    end
  end

  // registered read port, one cycle of latency
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rd_data_r <= DEFAULT_WORK_REG_RESET;
    end else begin
      rd_data_r <= default_work_reg_r[rd_sel];
    end
  end

  assign rd_data            = rd_data_r;
  assign mem_wr             = wr_r;
  assign status             = stat_r;
  assign arith_trap         = trap_r;
  assign accumulator_first  = acc_r[0];
  assign accumulator_second = acc_r[1];

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_acc_bad;
    op == OP_ACC_ARITH && sh_err && !acc_ld_en;
  endsequence
  sequence s_acc_first_ok;
    acc_ok && !acc_sel && !acc_ld_en;
  endsequence

  chk_trap_holds_acc: assert property (s_acc_bad |=> arith_trap
    && $stable(accumulator_first) && $stable(accumulator_second))
    else $error("out-of-range shift changed an accumulator or missed the trap");
  chk_trap_only_bad: assert property (arith_trap |-> $past(op) == OP_ACC_ARITH)
    else $error("trap raised without an accumulator shift");
  chk_right_sign_kept: assert property (s_acc_first_ok ##0 !sh_amt[5] |=>
    accumulator_first[39] == $past(accumulator_first[39]))
    else $error("right shift lost the accumulator sign");
  chk_clamp_in_range: assert property (s_acc_first_ok ##0 sh_sat_en |=>
    (&accumulator_first[39:31]) || !(|accumulator_first[39:31]))
    else $error("clamped accumulator outside the signed 32-bit range");
  chk_ovf_flag_acc: assert property (s_acc_first_ok |=>
    (status.overflow_flag_first == ((|accumulator_first[39:31])
    && !(&accumulator_first[39:31])))
    && (status.overflow_flag_either
      == (status.overflow_flag_first || status.overflow_flag_second)))
    else $error("overflow flag does not match the stored accumulator");
  chk_file_carry: assert property (op == OP_SHL_F && !byte_op |=>
    status.carry == $past(operand_rdata[15]))
    else $error("word file shift put the wrong bit in carry");
  chk_default_dest: assert property (op == OP_SHL_F && !file_dest && !byte_op
    && !ext_wr_en |=> default_work_reg_r[0] == {$past(operand_rdata[14:0]), 1'h0} && !mem_wr.valid)
    else $error("work register zero did not receive the shifted word");
  chk_byte_keeps_high: assert property (op == OP_SHL_F && !file_dest && byte_op
    && !ext_wr_en |=> default_work_reg_r[0][15:8] == $past(default_work_reg_r[0][15:8]))
    else $error("byte shift disturbed the upper byte");
  chk_file_write_addr: assert property (op == OP_SHL_F && file_dest |=>
    mem_wr.valid && mem_wr.addr == {3'h0, $past(instr[12:0])})
    else $error("file destination write missing or misaddressed");
  chk_lit_keeps_carry: assert property (op == OP_SHL_K |=>
    $stable(status.carry) && status.zero == (status.negative ? 1'h0 : status.zero))
    else $error("literal shift touched carry");
endmodule : slasu_unit
`default_nettype wire

// [bench/slasu_unit_tb.sv]
// Purpose: self-checking bench for the shift execution unit
// Assumes: inputs change on the falling edge, effects show one edge after acceptance
// Notes:   work registers are loaded through the core write port, not by instructions
`timescale 1ns/100ps
`default_nettype none
module slasu_unit_tb;
  import slasu_pkg::*;

  logic                 ref_clk = 1'b0;
  logic                 rst = 1'b1;
  logic                 instr_valid = 1'b0;
  logic [23:0]          instr = 24'h000000;
  logic [15:0]          operand_rdata = 16'h0000;
  logic [15:0]          core_control_reg = 16'h0000;
  logic                 clamp_flag_clear = 1'b0;
  logic                 ext_wr_en = 1'b0;
  logic [3:0]           ext_wr_sel = 4'h0;
  logic [15:0]          ext_wr_data = 16'h0000;
  logic                 acc_ld_en = 1'b0;
  logic                 acc_ld_sel = 1'b0;
  logic [39:0]          acc_ld_data = 40'h0000000000;
  logic [3:0]           rd_sel = 4'h0;
  logic [15:0]          rd_data;
  slasu_wr_t            mem_wr;
  slasu_stat_t          status;
  logic                 arith_trap;
  logic [39:0]          accumulator_first;
  logic [39:0]          accumulator_second;
  int                   error_cnt = 0;
  int                   n_tests = 0;

  // 50 MHz core clock
  always #10 ref_clk = ~ref_clk;

  slasu_unit u_slasu_unit (
    .ref_clk            (ref_clk),
    .rst                (rst),
    .instr_valid        (instr_valid),
    .instr              (instr),
    .operand_rdata      (operand_rdata),
    .core_control_reg   (core_control_reg),
    .clamp_flag_clear   (clamp_flag_clear),
    .ext_wr_en          (ext_wr_en),
    .ext_wr_sel         (ext_wr_sel),
    .ext_wr_data        (ext_wr_data),
    .acc_ld_en          (acc_ld_en),
    .acc_ld_sel         (acc_ld_sel),
    .acc_ld_data        (acc_ld_data),
    .rd_sel             (rd_sel),
    .rd_data            (rd_data),
    .mem_wr             (mem_wr),
    .status             (status),
    .arith_trap         (arith_trap),
    .accumulator_first  (accumulator_first),
    .accumulator_second (accumulator_second)
  );

  // compare tasks, one per kind of result; case equality keeps unknowns from matching
  task chk_w(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t word got %h exp %h", $time, got, exp);
    end
  endtask : chk_w

  task chk_a(input logic [39:0] got, input logic [39:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t acc got %h exp %h", $time, got, exp);
    end
  endtask : chk_a

  task chk_b(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t flag got %b exp %b", $time, got, exp);
    end
  endtask : chk_b

  // one instruction for one cycle; returns at the falling edge where its effects stand
  task exec(input logic [23:0] i, input logic [15:0] d);
    instr = i;
    operand_rdata = d;
    instr_valid = 1'b1;
    @(negedge ref_clk);
    instr_valid = 1'b0;
  endtask : exec

  task write_w(input logic [3:0] sel, input logic [15:0] d);
    ext_wr_en = 1'b1;
    ext_wr_sel = sel;
    ext_wr_data = d;
    @(negedge ref_clk);
    ext_wr_en = 1'b0;
    @(negedge ref_clk);                     // idle cycle: back-to-back writes never glitch the enable
  endtask : write_w

  task load_acc(input logic sel, input logic [39:0] d);
    acc_ld_en = 1'b1;
    acc_ld_sel = sel;
    acc_ld_data = d;
    @(negedge ref_clk);
    acc_ld_en = 1'b0;
  endtask : load_acc

  // read data is registered, so it is sampled one edge after the select
  task read_w(input logic [3:0] sel, input logic [15:0] exp);
    rd_sel = sel;
    @(negedge ref_clk);
    chk_w(rd_data, exp);
  endtask : read_w

  task end_test(input string name);
    $display("test %s done, mismatches so far %0d", name, error_cnt);
  endtask : end_test

  task conclude;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : conclude

  // watchdog: the whole sequence needs about 60 cycles
  initial begin
    repeat (3000) @(posedge ref_clk);
    error_cnt++;
    $display("BAD %0t watchdog expired", $time);
    conclude();
  end

  initial begin
    repeat (3) @(negedge ref_clk);
    rst = 1'b0;
    @(negedge ref_clk);
    chk_a(accumulator_first, ACC_RESET);
    chk_w({7'h00, status}, 16'h0000);
    chk_b(arith_trap, 1'b0);
    read_w(4'h0, DEFAULT_WORK_REG_RESET);
    end_test("reset");

    // left shift by four, no clamping: overflow into the guard bits
    load_acc(1'b0, 40'h00320fab09);
    write_w(4'h0, 16'hfffc);
    exec({8'hc8, 1'b0, 11'h000, 4'h0}, 16'h0000);
    chk_a(accumulator_first, 40'h0320fab090);
    chk_b(status.overflow_flag_first, 1'b1);
    chk_b(status.overflow_flag_either, 1'b1);
    // right shift by fifteen of the second accumulator replicates the sign
    core_control_reg = 16'h0040;
    load_acc(1'b1, 40'hfffff18f4c);
    write_w(4'hc, 16'h000f);
    exec({8'hc8, 1'b1, 11'h000, 4'hc}, 16'h0000);
    chk_a(accumulator_second, 40'hffffffffe3);
    chk_b(status.overflow_flag_second, 1'b0);
    chk_b(status.clamp_flag_second, 1'b0);
    // +16 is still inside the range
    write_w(4'h1, 16'h0010);
    exec({8'hc8, 1'b1, 11'h000, 4'h1}, 16'h0000);
    chk_b(arith_trap, 1'b0);
    chk_a(accumulator_second, 40'hffffffffff);
    end_test("acc_shift");

    // +17 and -17 trap and leave the accumulator alone
    write_w(4'h1, 16'h0011);
    exec({8'hc8, 1'b0, 11'h000, 4'h1}, 16'h0000);
    chk_b(arith_trap, 1'b1);
    chk_a(accumulator_first, 40'h0320fab090);
    write_w(4'h1, 16'h002f);
    exec({8'hc8, 1'b0, 11'h000, 4'h1}, 16'h0000);
    chk_b(arith_trap, 1'b1);
    chk_a(accumulator_first, 40'h0320fab090);
    @(negedge ref_clk);
    chk_b(arith_trap, 1'b0);
    end_test("acc_range");

    // clamping on the first accumulator, then clearing the sticky flags
    core_control_reg = 16'h0080;
    load_acc(1'b0, 40'h0040000000);
    exec({8'hc8, 1'b0, 11'h000, 4'h0}, 16'h0000);
    chk_a(accumulator_first, SAT_POS);
    chk_b(status.clamp_flag_first, 1'b1);
    chk_b(status.clamp_flag_either, 1'b1);
    chk_b(status.overflow_flag_first, 1'b0);
    core_control_reg = 16'h0000;
    clamp_flag_clear = 1'b1;
    @(negedge ref_clk);
    clamp_flag_clear = 1'b0;
    chk_b(status.clamp_flag_either, 1'b0);
    end_test("acc_clamp");

    // file shift, word, into the default work register
    exec({8'hd4, 1'b0, 1'b0, 1'b0, 13'h1650}, 16'h4065);
    chk_b(mem_wr.valid, 1'b0);
    chk_b(status.negative, 1'b1);
    chk_b(status.carry, 1'b0);
    read_w(4'h0, 16'h80ca);
    // file shift, byte, back to the file register at the top address
    exec({8'hd4, 1'b0, 1'b1, 1'b1, 13'h1fff}, 16'h0094);
    chk_b(mem_wr.valid, 1'b1);
    chk_b(mem_wr.byte_op, 1'b1);
    chk_w(mem_wr.addr, 16'h1fff);
    chk_w(mem_wr.data, 16'h2828);
    chk_b(status.carry, 1'b1);
    chk_b(status.negative, 1'b0);
    end_test("file_shift");

    // register shift, byte, direct: upper byte of the target kept
    write_w(4'h3, 16'h78a9);
    write_w(4'h4, 16'h1005);
    exec({8'hd0, 1'b0, 1'b1, AM_DIRECT, 4'h4, AM_DIRECT, 4'h3}, 16'h0000);
    chk_b(status.carry, 1'b1);
    read_w(4'h4, 16'h1052);
    // word, post-increment source into indirect target
    write_w(4'h2, 16'h0900);
    write_w(4'hc, 16'h1002);
    exec({8'hd0, 1'b0, 1'b0, 3'h1, 4'hc, AM_POSTINC, 4'h2}, 16'h800f);
    chk_b(mem_wr.valid, 1'b1);
    chk_w(mem_wr.addr, 16'h1002);
    chk_w(mem_wr.data, 16'h001e);
    chk_b(status.carry, 1'b1);
    read_w(4'h2, 16'h0900 + STEP_WORD);
    // a result of zero sets the zero flag
    write_w(4'h5, 16'h8000);
    exec({8'hd0, 1'b0, 1'b0, AM_DIRECT, 4'h6, AM_DIRECT, 4'h5}, 16'h0000);
    chk_b(status.zero, 1'b1);
    chk_b(status.carry, 1'b1);
    read_w(4'h6, 16'h0000);
    end_test("reg_shift");

    // literal shift: carry stays at one since only negative and zero change
    write_w(4'h2, 16'h78a9);
    exec({8'hdd, 1'b0, 4'h2, 4'h2, LIT_PATTERN, 4'h4}, 16'h0000);
    chk_b(status.negative, 1'b1);
    chk_b(status.zero, 1'b0);
    chk_b(status.carry, 1'b1);
    read_w(4'h2, 16'h8a90);
    write_w(4'h3, 16'h0912);
    exec({8'hdd, 1'b0, 4'h3, 4'h8, LIT_PATTERN, 4'hc}, 16'h0000);
    read_w(4'h8, 16'h2000);
    exec({8'hdd, 1'b0, 4'h3, 4'h9, LIT_PATTERN, 4'hf}, 16'h0000);
    read_w(4'h9, 16'h0000);
    chk_b(status.zero, 1'b1);
    exec({8'hdd, 1'b0, 4'h3, 4'ha, LIT_PATTERN, 4'h0}, 16'h0000);
    read_w(4'ha, 16'h0912);
    // a wrong pattern ahead of the literal is ignored
    exec({8'hdd, 1'b0, 4'h3, 4'h8, 3'h5, 4'h1}, 16'h0000);
    read_w(4'h8, 16'h2000);
    end_test("literal_shift");
    conclude();
  end
endmodule : slasu_unit_tb
`default_nettype wire
